// ---- rtl/tcpef_flags.sv ----
// How it works
// R1 - First flag register resets zero, write-one clears
// R2 - Second flag register resets zero, write-one clears
// R3 - Bit 6: orientation leaves 00 to 01/10
// R4 - Bit 5: CC above Rd range with Rd
// R5 - Bit 4: VBUS crosses either threshold
// R6 - Bit 3: automatic sink mode entered or left
// R7 - Bit 2: advertised current level changes
// R8 - Bit 1: attached party removed
// R9 - Bit 0: device or accessory attached
// R10 - Second bit 6: request VBUS off, discharge
// R11 - Second bit 5: request VBUS on
// R12 - Second bit 3: stable attach recovery failed
// R13 - Second bit 2: forced role request failed
// R14 - Second bit 1: forced role request succeeded
// R15 - Second bit 0: recovery procedures started
// R16 - Flags hold until written one; set wins
// R17 - Reserved bits read zero, host writes zero
module tcpef_flags
(
    // Clock and reset
    input  wire logic                   CORE_CLK,
    input  wire logic                   RST_B,
    // Register port
    input  wire logic [7:0]             REG_ADDR,
    input  wire logic                   REG_WR,
    input  wire logic [7:0]             REG_WDATA,
    output logic      [7:0]             REG_RDATA,
    // Detection logic
    input  tcpef_pkg::tcpef_level_t     DET_LEVEL,
    input  tcpef_pkg::tcpef_pulse_t     DET_PULSE
);
    import tcpef_pkg::*;

    // ==========================================================
    // State
    logic [7:0]   port_flags;
    logic [7:0]   recov_flags;
    tcpef_level_t prev;
    logic         primed;

    // ==========================================================
    // Decode
    wire         hit_port   = REG_WR && (REG_ADDR == TCPEF_ADDR_PORT_EVT);
    wire         hit_recov  = REG_WR && (REG_ADDR == TCPEF_ADDR_RECOV_EVT);
    wire   [7:0] clr_port   = hit_port  ? REG_WDATA : TCPEF_RESET_VAL;
    wire   [7:0] clr_recov  = hit_recov ? REG_WDATA : TCPEF_RESET_VAL;

    // ==========================================================
    // Level change detection
    // R3 orientation edge
    wire cable_flip_field_evt  = primed && (prev.cable_flip_field == TCPEF_DIR_NONE)
                     && ((DET_LEVEL.cable_flip_field == TCPEF_DIR_CC1)
                      || (DET_LEVEL.cable_flip_field == TCPEF_DIR_CC2));
    // R4 fault qualified by Rd
    wire [1:0] fault_now  = {DET_LEVEL.cc2_above_rd && DET_LEVEL.cc2_rd_on,
                             DET_LEVEL.cc1_above_rd && DET_LEVEL.cc1_rd_on};
    wire [1:0] fault_prev = {prev.cc2_above_rd && prev.cc2_rd_on,
                             prev.cc1_above_rd && prev.cc1_rd_on};
    wire fault_evt   = primed && |(fault_now & ~fault_prev);
    // R5 threshold crossing
    wire vbus_evt    = primed && ((DET_LEVEL.vbus_above_low != prev.vbus_above_low)
                     || (DET_LEVEL.vbus_above_high != prev.vbus_above_high));
    // R6 sink mode toggle
    wire automatic_sink_mode_evt = primed && (DET_LEVEL.automatic_sink_mode != prev.automatic_sink_mode);
    // R7 current level change
    wire curlvl_evt  = primed && (DET_LEVEL.advertised_current_level != prev.advertised_current_level);

    // ==========================================================
    // Set vectors
    logic [7:0] set_port;
    logic [7:0] set_recov;
    always_comb
    begin
        set_port                      = TCPEF_RESET_VAL;
        set_port[TCPEF_BIT_PLUGDIR]   = cable_flip_field_evt;
        set_port[TCPEF_BIT_CCFAULT]   = fault_evt;
        set_port[TCPEF_BIT_VBUS]      = vbus_evt;
        set_port[TCPEF_BIT_AUTOMATIC_SINK_MODE]   = automatic_sink_mode_evt;
        set_port[TCPEF_BIT_CURLVL]    = curlvl_evt;
        // R8 removal pulse
        set_port[TCPEF_BIT_REMOVAL]   = DET_PULSE.removal;
        // R9 attach pulse
        set_port[TCPEF_BIT_ATTACH]    = DET_PULSE.attach;
        set_recov                     = TCPEF_RESET_VAL;
        // R10 VBUS off request
        set_recov[TCPEF_BIT_VBOFF]    = DET_PULSE.vbus_off_req;
        // R11 VBUS on request
        set_recov[TCPEF_BIT_VBON]     = DET_PULSE.vbus_on_req;
        // R12 recovery failed
        set_recov[TCPEF_BIT_RFAIL]    = DET_PULSE.recovery_fail;
        // R13 forced role failed
        set_recov[TCPEF_BIT_FRCFAIL]  = DET_PULSE.forced_fail;
        // R14 forced role done
        set_recov[TCPEF_BIT_FRCDONE]  = DET_PULSE.forced_done;
        // R15 recovery started
        set_recov[TCPEF_BIT_RSTART]   = DET_PULSE.recovery_start;
    end

    // ==========================================================
    // Next values
    // R16 set beats clear
    // R17 reserved forced low
    wire [7:0] next_port  = ((port_flags  & ~clr_port)  | set_port)  & TCPEF_PORT_MASK;
    wire [7:0] next_recov = ((recov_flags & ~clr_recov) | set_recov) & TCPEF_RECOV_MASK;
    wire [7:0] next_rdata = (REG_ADDR == TCPEF_ADDR_PORT_EVT)  ? port_flags  :
                            (REG_ADDR == TCPEF_ADDR_RECOV_EVT) ? recov_flags : TCPEF_RESET_VAL;

    // ==========================================================
    // Flag registers
    // R1 R2 reset and clear
    always_ff @(posedge CORE_CLK)
    begin
        if (!RST_B)
        begin
            port_flags  <= TCPEF_RESET_VAL;
            recov_flags <= TCPEF_RESET_VAL;
        end
        else
        begin
            port_flags  <= next_port;
            recov_flags <= next_recov;
        end
    end

    // ==========================================================
    // Level history and read data
    always_ff @(posedge CORE_CLK)
    begin
        if (!RST_B)
        begin
            prev      <= '0;
            primed    <= 1'b0;
            REG_RDATA <= TCPEF_RESET_VAL;
        end
        else
        begin
            prev      <= DET_LEVEL;
            primed    <= 1'b1;
            REG_RDATA <= next_rdata;
        end
    end

    // ==========================================================
    // Assertions
    default clocking cb @(posedge CORE_CLK); endclocking
    default disable iff (!RST_B);

    sequence s_in_reset;
        !RST_B;
    endsequence

    sequence s_regs_zero;
        (port_flags == TCPEF_RESET_VAL) && (recov_flags == TCPEF_RESET_VAL);
    endsequence

    property p_reset_zero;
        @(posedge CORE_CLK) disable iff (1'b0)
        s_in_reset |=> s_regs_zero;
    endproperty
    a_reset_zero: assert property (p_reset_zero) else $error("flags not zero after reset"); // R1

    sequence s_clear_recov_bit0;
        hit_recov && REG_WDATA[TCPEF_BIT_RSTART] && !DET_PULSE.recovery_start;
    endsequence

    property p_recov_clear;
        s_clear_recov_bit0 |=> !recov_flags[TCPEF_BIT_RSTART];
    endproperty
    a_recov_clear: assert property (p_recov_clear) else $error("recovery flag not cleared"); // R2

    property p_port_clear;
        hit_port && REG_WDATA[TCPEF_BIT_ATTACH] && !DET_PULSE.attach |=> !port_flags[TCPEF_BIT_ATTACH];
    endproperty
    a_port_clear: assert property (p_port_clear) else $error("attach flag not cleared"); // R1

    property p_cable_flip_field;
        primed && (prev.cable_flip_field == TCPEF_DIR_NONE) && (DET_LEVEL.cable_flip_field == TCPEF_DIR_CC2)
        |=> port_flags[TCPEF_BIT_PLUGDIR];
    endproperty
    a_cable_flip_field: assert property (p_cable_flip_field) else $error("orientation flag missed"); // R3

    property p_cable_flip_field_11;
        !port_flags[TCPEF_BIT_PLUGDIR] && (DET_LEVEL.cable_flip_field == 2'h3)
        |=> !port_flags[TCPEF_BIT_PLUGDIR];
    endproperty
    a_cable_flip_field_11: assert property (p_cable_flip_field_11) else $error("orientation flag on 11"); // R3

    property p_fault;
        primed && DET_LEVEL.cc1_above_rd && DET_LEVEL.cc1_rd_on && !fault_prev[0]
        |=> port_flags[TCPEF_BIT_CCFAULT];
    endproperty
    a_fault: assert property (p_fault) else $error("cc fault flag missed"); // R4

    property p_vbus;
        primed && $changed(DET_LEVEL.vbus_above_high) |-> ##1 port_flags[TCPEF_BIT_VBUS];
    endproperty
    a_vbus: assert property (p_vbus) else $error("vbus flag missed"); // R5

    property p_automatic_sink_mode;
        primed && $changed(DET_LEVEL.automatic_sink_mode) |=> port_flags[TCPEF_BIT_AUTOMATIC_SINK_MODE];
    endproperty
    a_automatic_sink_mode: assert property (p_automatic_sink_mode) else $error("sink mode flag missed"); // R6

    property p_curlvl;
        primed && (DET_LEVEL.advertised_current_level != prev.advertised_current_level)
        |=> port_flags[TCPEF_BIT_CURLVL];
    endproperty
    a_curlvl: assert property (p_curlvl) else $error("current level flag missed"); // R7

    property p_removal;
        DET_PULSE.removal |=> port_flags[TCPEF_BIT_REMOVAL];
    endproperty
    a_removal: assert property (p_removal) else $error("removal flag missed"); // R8

    property p_vboff;
        DET_PULSE.vbus_off_req |=> recov_flags[TCPEF_BIT_VBOFF];
    endproperty
    a_vboff: assert property (p_vboff) else $error("vbus off request missed"); // R10

    property p_frcfail;
        DET_PULSE.forced_fail && hit_recov && REG_WDATA[TCPEF_BIT_FRCFAIL] |=> recov_flags[TCPEF_BIT_FRCFAIL];
    endproperty
    a_frcfail: assert property (p_frcfail) else $error("set lost to clear"); // R13

    sequence s_hold_no_clear;
        port_flags[TCPEF_BIT_VBUS] && !clr_port[TCPEF_BIT_VBUS];
    endsequence

    property p_hold;
        s_hold_no_clear |=> port_flags[TCPEF_BIT_VBUS];
    endproperty
    a_hold: assert property (p_hold) else $error("flag dropped without clear"); // R16

    property p_reserved;
        (port_flags[7] == 1'b0) && (recov_flags[7] == 1'b0) && (recov_flags[4] == 1'b0);
    endproperty
    a_reserved: assert property (p_reserved) else $error("reserved bit set"); // R17

    property p_readback;
        REG_ADDR == TCPEF_ADDR_RECOV_EVT |=> REG_RDATA == $past(recov_flags);
    endproperty
    a_readback: assert property (p_readback) else $error("read data mismatch"); // R2

    property p_readback_port;
        REG_ADDR == TCPEF_ADDR_PORT_EVT |=> REG_RDATA == $past(port_flags);
    endproperty
    a_readback_port: assert property (p_readback_port) else $error("port read data mismatch"); // R1

    property p_unmapped_read;
        (REG_ADDR != TCPEF_ADDR_PORT_EVT) && (REG_ADDR != TCPEF_ADDR_RECOV_EVT)
        |=> REG_RDATA == TCPEF_RESET_VAL;
    endproperty
    a_unmapped_read: assert property (p_unmapped_read) else $error("unmapped read not zero"); // R17

    property p_attach;
        DET_PULSE.attach |=> port_flags[TCPEF_BIT_ATTACH];
    endproperty
    a_attach: assert property (p_attach) else $error("attach flag missed"); // R9

    property p_vbon;
        DET_PULSE.vbus_on_req |=> recov_flags[TCPEF_BIT_VBON];
    endproperty
    a_vbon: assert property (p_vbon) else $error("vbus on request missed"); // R11

    property p_rfail;
        DET_PULSE.recovery_fail |=> recov_flags[TCPEF_BIT_RFAIL];
    endproperty
    a_rfail: assert property (p_rfail) else $error("recovery failed flag missed"); // R12

    property p_frcdone;
        DET_PULSE.forced_done |=> recov_flags[TCPEF_BIT_FRCDONE];
    endproperty
    a_frcdone: assert property (p_frcdone) else $error("forced role done flag missed"); // R14

    property p_rstart;
        DET_PULSE.recovery_start |=> recov_flags[TCPEF_BIT_RSTART];
    endproperty
    a_rstart: assert property (p_rstart) else $error("recovery started flag missed"); // R15

    property p_cable_flip_field_cc1;
        primed && (prev.cable_flip_field == TCPEF_DIR_NONE) && (DET_LEVEL.cable_flip_field == TCPEF_DIR_CC1)
        |=> port_flags[TCPEF_BIT_PLUGDIR];
    endproperty
    a_cable_flip_field_cc1: assert property (p_cable_flip_field_cc1) else $error("orientation flag missed on first pin"); // R3

    property p_cable_flip_field_none;
        !port_flags[TCPEF_BIT_PLUGDIR] && (DET_LEVEL.cable_flip_field == TCPEF_DIR_NONE)
        |=> !port_flags[TCPEF_BIT_PLUGDIR];
    endproperty
    a_cable_flip_field_none: assert property (p_cable_flip_field_none) else $error("orientation flag on return to none"); // R3

    property p_fault_cc2;
        primed && DET_LEVEL.cc2_above_rd && DET_LEVEL.cc2_rd_on && !fault_prev[1]
        |=> port_flags[TCPEF_BIT_CCFAULT];
    endproperty
    a_fault_cc2: assert property (p_fault_cc2) else $error("cc fault flag missed on second pin"); // R4

    property p_fault_no_rd;
        !port_flags[TCPEF_BIT_CCFAULT] && !DET_LEVEL.cc1_rd_on && !DET_LEVEL.cc2_rd_on
        |=> !port_flags[TCPEF_BIT_CCFAULT];
    endproperty
    a_fault_no_rd: assert property (p_fault_no_rd) else $error("cc fault flag without termination"); // R4

    property p_vbus_low;
        primed && (DET_LEVEL.vbus_above_low != prev.vbus_above_low)
        |=> port_flags[TCPEF_BIT_VBUS];
    endproperty
    a_vbus_low: assert property (p_vbus_low) else $error("vbus low threshold flag missed"); // R5

    property p_hold_recov;
        recov_flags[TCPEF_BIT_RFAIL] && !clr_recov[TCPEF_BIT_RFAIL] |=> recov_flags[TCPEF_BIT_RFAIL];
    endproperty
    a_hold_recov: assert property (p_hold_recov) else $error("recovery flag dropped without clear"); // R16

endmodule : tcpef_flags

// ---- rtl/tcpef_pkg.sv ----
package tcpef_pkg;

    // ==========================================================
    // Register map
    localparam logic [7:0] TCPEF_ADDR_PORT_EVT  = 8'h14;
    localparam logic [7:0] TCPEF_ADDR_RECOV_EVT = 8'h15;
    localparam logic [7:0] TCPEF_RESET_VAL      = 8'h00;

    // ==========================================================
    // Implemented bits; reserved bits read zero
    localparam logic [7:0] TCPEF_PORT_MASK      = 8'h7f;
    localparam logic [7:0] TCPEF_RECOV_MASK     = 8'h6f;

    // ==========================================================
    // Bit positions, port event flags
    localparam int TCPEF_BIT_ATTACH   = 0;
    localparam int TCPEF_BIT_REMOVAL  = 1;
    localparam int TCPEF_BIT_CURLVL   = 2;
    localparam int TCPEF_BIT_AUTOMATIC_SINK_MODE  = 3;
    localparam int TCPEF_BIT_VBUS     = 4;
    localparam int TCPEF_BIT_CCFAULT  = 5;
    localparam int TCPEF_BIT_PLUGDIR  = 6;

    // ==========================================================
    // Bit positions, recovery event flags
    localparam int TCPEF_BIT_RSTART   = 0;
    localparam int TCPEF_BIT_FRCDONE  = 1;
    localparam int TCPEF_BIT_FRCFAIL  = 2;
    localparam int TCPEF_BIT_RFAIL    = 3;
    localparam int TCPEF_BIT_VBON     = 5;
    localparam int TCPEF_BIT_VBOFF    = 6;

    // ==========================================================
    // Orientation codes
    localparam logic [1:0] TCPEF_DIR_NONE = 2'h0;
    localparam logic [1:0] TCPEF_DIR_CC1  = 2'h1;
    localparam logic [1:0] TCPEF_DIR_CC2  = 2'h2;

    // ==========================================================
    // Level inputs from the detection logic
    typedef struct packed {
        logic [1:0] cable_flip_field;
        logic       cc1_above_rd;
        logic       cc2_above_rd;
        logic       cc1_rd_on;
        logic       cc2_rd_on;
        logic       vbus_above_low;
        logic       vbus_above_high;
        logic       automatic_sink_mode;
        logic [1:0] advertised_current_level;
    } tcpef_level_t;

    // One-cycle event pulses from the detection logic
    typedef struct packed {
        logic attach;
        logic removal;
        logic recovery_start;
        logic vbus_off_req;
        logic vbus_on_req;
        logic recovery_fail;
        logic forced_fail;
        logic forced_done;
    } tcpef_pulse_t;

endpackage : tcpef_pkg

// ---- verif/tcpef_host.sv ----
module tcpef_host
(
    // Clock
    input  wire logic       CORE_CLK,
    // Register port
    output logic [7:0]      REG_ADDR,
    output logic            REG_WR,
    output logic [7:0]      REG_WDATA,
    input  wire logic [7:0] REG_RDATA
);
    timeunit 1ns;
    timeprecision 1ps;
    import tcpef_pkg::*;

    initial
    begin
        REG_ADDR  = 8'h00;
        REG_WR    = 1'b0;
        REG_WDATA = 8'h00;
    end

    // ==========================================================
    // Single write, data line inverted once released
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge CORE_CLK);
        REG_ADDR  <= a;
        REG_WR    <= 1'b1;
        REG_WDATA <= d;
        @(posedge CORE_CLK);
        REG_WR    <= 1'b0;
        REG_WDATA <= ~d;
    endtask : wr

    // ==========================================================
    // Read, data taken settled after the capture edge
    task automatic rd(input logic [7:0] a, output logic [7:0] d);
        @(posedge CORE_CLK);
        REG_ADDR <= a;
        @(posedge CORE_CLK);
        @(negedge CORE_CLK);
        d = REG_RDATA;
    endtask : rd

    task automatic clear_all();
        wr(TCPEF_ADDR_PORT_EVT, TCPEF_PORT_MASK);
        wr(TCPEF_ADDR_RECOV_EVT, TCPEF_RECOV_MASK);
    endtask : clear_all

endmodule : tcpef_host

// ---- verif/test_typec_port_event_flags.sv ----
module test_typec_port_event_flags;
    timeunit 1ns;
    timeprecision 1ps;
    import tcpef_pkg::*;

    // ==========================================================
    // Signals
    logic         core_clk;
    logic         rst_b;
    logic [7:0]   reg_addr;
    logic         reg_wr;
    logic [7:0]   reg_wdata;
    logic [7:0]   reg_rdata;
    tcpef_level_t lev;
    tcpef_pulse_t pul;
    int           n_mismatch;
    int           total_checks;
    int           cycles;

    tcpef_flags i_tcpef_flags (.CORE_CLK(core_clk), .RST_B(rst_b), .REG_ADDR(reg_addr), .REG_WR(reg_wr),
        .REG_WDATA(reg_wdata), .REG_RDATA(reg_rdata), .DET_LEVEL(lev), .DET_PULSE(pul));
    tcpef_host i_tcpef_host (.CORE_CLK(core_clk), .REG_ADDR(reg_addr), .REG_WR(reg_wr),
        .REG_WDATA(reg_wdata), .REG_RDATA(reg_rdata));

    always #4 core_clk = ~core_clk;

    // ==========================================================
    // Helpers
    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        total_checks++;
        if (seen !== exp)
        begin
            n_mismatch++;
            $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask : check

    task automatic regs_are(input logic [7:0] p, input logic [7:0] r);
        logic [7:0] d;
        i_tcpef_host.rd(TCPEF_ADDR_PORT_EVT, d);
        check(d, p);
        i_tcpef_host.rd(TCPEF_ADDR_RECOV_EVT, d);
        check(d, r);
    endtask : regs_are

    task automatic pulse(input tcpef_pulse_t p);
        @(posedge core_clk);
        pul <= p;
        @(posedge core_clk);
        pul <= '0;
    endtask : pulse

    task automatic step(input tcpef_level_t v, input logic [7:0] p);
        @(posedge core_clk);
        lev <= v;
        regs_are(p, 8'h00);
        i_tcpef_host.clear_all();
    endtask : step

    // ==========================================================
    // Scenarios
    task automatic t_pulses();
        logic [7:0] ep [8];
        logic [7:0] er [8];
        ep = '{8'h01, 8'h02, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00};
        er = '{8'h00, 8'h00, 8'h01, 8'h40, 8'h20, 8'h08, 8'h04, 8'h02};
        for (int i = 0; i < 8; i++)
        begin
            pulse(tcpef_pulse_t'(8'h80 >> i));
            regs_are(ep[i], er[i]); // event bit set
            i_tcpef_host.clear_all();
            regs_are(8'h00, 8'h00); // cleared by write one
        end
    endtask : t_pulses

    task automatic t_levels();
        tcpef_level_t v;
        v = '0;
        v.cable_flip_field = TCPEF_DIR_CC1;
        step(v, 8'h40); // first pin
        v.cable_flip_field = TCPEF_DIR_NONE;
        step(v, 8'h00); // return to none
        v.cable_flip_field = 2'h3;
        step(v, 8'h00); // both bits
        v.cable_flip_field = TCPEF_DIR_NONE;
        step(v, 8'h00); // return to none
        v.cable_flip_field = TCPEF_DIR_CC2;
        step(v, 8'h40); // second pin
        v.automatic_sink_mode = 1'b1;
        step(v, 8'h08); // entered
        v.automatic_sink_mode = 1'b0;
        step(v, 8'h08); // left
        v.advertised_current_level = 2'h3;
        step(v, 8'h04); // level change
        v.vbus_above_low = 1'b1;
        step(v, 8'h10); // low threshold
        v.vbus_above_high = 1'b1;
        step(v, 8'h10); // high threshold
        v.vbus_above_low = 1'b0;
        v.vbus_above_high = 1'b0;
        step(v, 8'h10); // both falling
        v.cc1_above_rd = 1'b1;
        step(v, 8'h00); // no termination
        v.cc1_rd_on = 1'b1;
        step(v, 8'h20); // first pin
        v.cc2_rd_on = 1'b1;
        v.cc2_above_rd = 1'b1;
        step(v, 8'h20); // second pin
        v = '0;
        step(v, 8'h04); // releases silent, level change flags
    endtask : t_levels

    task automatic t_hold();
        tcpef_pulse_t a;
        logic [7:0]   d;
        a = '0;
        a.attach = 1'b1;
        pulse(a);
        i_tcpef_host.wr(TCPEF_ADDR_PORT_EVT, 8'h00);
        i_tcpef_host.wr(8'h16, 8'h01);
        regs_are(8'h01, 8'h00); // zero write and stray address
        i_tcpef_host.rd(8'h16, d);
        check(d, 8'h00); // unmapped reads zero
        fork
            i_tcpef_host.wr(TCPEF_ADDR_PORT_EVT, 8'h01);
            pulse(a);
        join
        regs_are(8'h01, 8'h00); // set wins over clear
        i_tcpef_host.clear_all();
        regs_are(8'h00, 8'h00); // cleared
    endtask : t_hold

    task automatic t_reset();
        tcpef_level_t v;
        v = '0;
        v.cable_flip_field = TCPEF_DIR_CC1;
        pulse(tcpef_pulse_t'(8'hff));
        regs_are(8'h03, 8'h6f); // reserved stay zero
        @(posedge core_clk);
        lev   <= v;
        rst_b <= 1'b0;
        repeat (2) @(posedge core_clk);
        rst_b <= 1'b1;
        regs_are(8'h00, 8'h00); // reset clears, no false edge
    endtask : t_reset

    // ==========================================================
    // Closing and timeout
    task automatic final_report();
        $display("checks %0d mismatches %0d", total_checks, n_mismatch);
        if (n_mismatch == 0 && total_checks > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask : final_report

    always @(posedge core_clk)
    begin
        cycles++;
        if (cycles == 3000)
        begin
            n_mismatch++;
            final_report();
        end
    end

    initial
    begin
        core_clk = 1'b0;
        rst_b    = 1'b0;
        lev      = '0;
        pul      = '0;
        repeat (2) @(posedge core_clk);
        rst_b <= 1'b1;
        regs_are(8'h00, 8'h00); // reset value
        t_pulses();
        t_levels();
        t_hold();
        t_reset();
        final_report();
    end

endmodule : test_typec_port_event_flags
